/* File: rcbf_boot_mem.sv */
// behavioural boot memory answering the vector fetch
`timescale 1ns/100ps
`default_nettype none
module rcbf_boot_mem
#(
	parameter logic [31:0] SP_WORD = 32'h2000_FF00,
	parameter logic [31:0] PC_WORD = 32'hF000_0400
)
(
	// clock
	input wire logic        ref_clk,
	// boot bus
	input wire logic        rd_req,
	input wire logic [31:0] rd_addr,
	output logic            rd_ack,
	output logic [31:0]     rd_data,
	output logic            access_err,
	output logic            addr_err,
	// test control
	input wire logic [7:0]  lat,
	input wire logic [1:0]  err_sel
);
	logic [7:0] cnt_q;
	initial
	begin
		rd_ack = 1'b0;
		rd_data = 32'h0000_0000;
		access_err = 1'b0;
		addr_err = 1'b0;
		cnt_q = 8'h00;
	end
	always @(posedge ref_clk)
	begin
		rd_ack <= 1'b0;
		access_err <= 1'b0;
		addr_err <= 1'b0;
		// idle data toggles so a stale word never looks valid
		rd_data <= ~rd_data;
		cnt_q <= 8'h00;
		if (rd_req && !rd_ack)
		begin
			cnt_q <= cnt_q + 8'h01;
			if (cnt_q >= lat)
			begin
				rd_ack <= 1'b1;
				cnt_q <= 8'h00;
				rd_data <= (rd_addr == 32'h0000_0004) ? PC_WORD : SP_WORD;
				access_err <= err_sel[0];
				addr_err <= err_sel[1];
			end
		end
	end
endmodule : rcbf_boot_mem
`default_nettype wire

/* File: rcbf_cfg_latch.sv */
// reset configuration capture and clock mode decode
`timescale 1ns/100ps
`default_nettype none
`include "rcbf_regs.svh"
module rcbf_cfg_latch
(
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	// capture strobe
	input  wire logic         capture,
	// strapping
	input  wire logic         reset_config_enable_n,
	input  wire logic [31:0]  data_pins,
	input  wire logic         debug_port_sel,
	// latched configuration
	output logic [1:0]        boot_sel,
	output logic [1:0]        clk_mode,
	output logic [2:0]        chip_mode,
	output logic              drive_full,
	output logic [1:0]        addr_mode,
	output logic              dbg_sel_jtag,
	output logic [3:0]        clk_onehot
);
	////////////////////////////////////////////////////////////////////////////////
	wire        use_pins    = ~reset_config_enable_n;
	wire [1:0]  boot_d      = use_pins ? data_pins[19:18] : `RCBF_DFLT_BOOT;
	wire [1:0]  clk_d       = use_pins ? data_pins[1:0]   : `RCBF_DFLT_CLK_MODE;
	wire [2:0]  chip_d      = use_pins ? data_pins[4:2]   : `RCBF_DFLT_CHIP_MODE;
	wire        drive_d     = use_pins ? data_pins[5]     : `RCBF_DFLT_DRIVE;
	wire [1:0]  addr_d      = use_pins ? data_pins[7:6]   : `RCBF_DFLT_ADDR_MODE;
	////////////////////////////////////////////////////////////////////////////////
	// values are caught once on the capture pulse and then frozen until next reset
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			boot_sel     <= `RCBF_DFLT_BOOT;
			clk_mode     <= `RCBF_DFLT_CLK_MODE;
			chip_mode    <= `RCBF_DFLT_CHIP_MODE;
			drive_full   <= `RCBF_DFLT_DRIVE;
			addr_mode    <= `RCBF_DFLT_ADDR_MODE;
			dbg_sel_jtag <= `RCBF_DFLT_DBG_SEL;
		end
		else if (capture)
		begin
			boot_sel     <= boot_d;
			clk_mode     <= clk_d;
			chip_mode    <= chip_d;
			drive_full   <= drive_d;
			addr_mode    <= addr_d;
			dbg_sel_jtag <= debug_port_sel;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_clk
			assign clk_onehot[gi] = (clk_mode == 2'(gi));
		end
	endgenerate
endmodule : rcbf_cfg_latch
`default_nettype wire

/* File: rcbf_monitor.sv */
// concurrent checks on the reset sequencer and boot fetch ports
`timescale 1ns/100ps
`default_nettype none
module rcbf_monitor
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// boot bus
	input wire logic        bus_grant,
	input wire logic        rd_req,
	input wire logic [31:0] rd_addr,
	input wire logic        boot_chip_select,
	input wire logic [1:0]  port_width,
	input wire logic        rd_ack,
	input wire logic [31:0] rd_data,
	input wire logic        access_err,
	input wire logic        addr_err,
	// core state
	input wire logic        core_run,
	input wire logic        core_halted,
	input wire logic [31:0] stack_ptr,
	input wire logic [31:0] prog_ctr,
	input wire logic [15:0] status_word,
	input wire logic [31:0] vector_base_pointer,
	input wire logic [3:0]  clk_mode_sel,
	input wire logic        dbg_sel_jtag,
	input wire logic        local_mem_en
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	// reset effects seen at the first edge after release
	property p_rst_idle; $fell(sys_rst) |-> !core_run && !core_halted && !rd_req; endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("core not idle after reset");
	property p_rst_sw; $fell(sys_rst) |-> status_word == 16'h2700; endproperty
	a_rst_sw: assert property (p_rst_sw) else $error("status word wrong after reset");
	property p_rst_vbp; $fell(sys_rst) |-> vector_base_pointer == 32'h0000_0000; endproperty
	a_rst_vbp: assert property (p_rst_vbp) else $error("vector base not zero after reset");
	property p_rst_mem; $fell(sys_rst) |-> !local_mem_en; endproperty
	a_rst_mem: assert property (p_rst_mem) else $error("local memory enabled after reset");
	////////////////////////////////////////
	property p_sp; rd_req && rd_addr == 32'h0 && rd_ack && !access_err && !addr_err
		|=> rd_req && rd_addr == 32'h4 && stack_ptr == $past(rd_data); endproperty
	a_sp: assert property (p_sp) else $error("stack pointer fetch wrong");
	property p_pc; rd_req && rd_addr == 32'h4 && rd_ack && !access_err && !addr_err
		|=> core_run && !rd_req && prog_ctr == $past(rd_data); endproperty
	a_pc: assert property (p_pc) else $error("program counter fetch wrong");
	property p_halt; rd_req && rd_ack && (access_err || addr_err) |=> core_halted && !core_run && !rd_req; endproperty
	a_halt: assert property (p_halt) else $error("fault did not halt");
	property p_halt_hold; core_halted |=> core_halted && !rd_req; endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("halt left without reset");
	property p_cs; rd_req |-> boot_chip_select == (port_width != 2'h0); endproperty
	a_cs: assert property (p_cs) else $error("boot chip select wrong");
	property p_clk; core_run |-> $onehot(clk_mode_sel); endproperty
	a_clk: assert property (p_clk) else $error("clock mode not one-hot");
	property p_hold; core_run && $past(core_run)
		|-> $stable(port_width) && $stable(clk_mode_sel) && $stable(dbg_sel_jtag); endproperty
	a_hold: assert property (p_hold) else $error("latched config changed");
	property p_grant; $rose(rd_req) |-> $past(bus_grant); endproperty
	a_grant: assert property (p_grant) else $error("fetch began without grant");
endmodule : rcbf_monitor
bind rcbf_top rcbf_monitor mon_u (.ref_clk, .sys_rst, .bus_grant, .rd_req, .rd_addr, .boot_chip_select,
	.port_width, .rd_ack, .rd_data, .access_err, .addr_err, .core_run, .core_halted, .stack_ptr, .prog_ctr,
	.status_word, .vector_base_pointer, .clk_mode_sel, .dbg_sel_jtag, .local_mem_en);
`default_nettype wire

/* File: rcbf_pkg.sv */
// types shared by the reset config and boot fetch design
`default_nettype none
package rcbf_pkg;
	typedef enum logic [1:0] {
		RCBF_BOOT_INT32 = 2'h0,
		RCBF_BOOT_EXT16 = 2'h1,
		RCBF_BOOT_EXT8  = 2'h2,
		RCBF_BOOT_EXT32 = 2'h3
	} rcbf_boot_t;
	typedef enum logic [1:0] {
		RCBF_CLK_EXT_NOPLL = 2'h0,
		RCBF_CLK_PLL_1TO1  = 2'h1,
		RCBF_CLK_PLL_EXTRF = 2'h2,
		RCBF_CLK_PLL_XTAL  = 2'h3
	} rcbf_clk_t;
	typedef enum logic [2:0] {
		RCBF_ST_RESET   = 3'h0,
		RCBF_ST_LATCH   = 3'h1,
		RCBF_ST_CSCFG   = 3'h2,
		RCBF_ST_FETCHSP = 3'h3,
		RCBF_ST_FETCHPC = 3'h4,
		RCBF_ST_RUN     = 3'h5,
		RCBF_ST_HALT    = 3'h6
	} rcbf_state_t;
endpackage : rcbf_pkg
`default_nettype wire

/* File: rcbf_regs.svh */
// register offsets, field positions, reset values and timing counts for the reset config and boot fetch block
`ifndef RCBF_REGS_SVH
`define RCBF_REGS_SVH
`define RCBF_OFF_CTRL        8'h00
`define RCBF_OFF_STATUS      8'h04
`define RCBF_OFF_CONFIG      8'h08
`define RCBF_OFF_SP          8'h0C
`define RCBF_OFF_PC          8'h10
`define RCBF_OFF_STATUS_WORD 8'h14
`define RCBF_OFF_VBP         8'h18
`define RCBF_OFF_MEMCTL      8'h1C
`define RCBF_SP_ADDR         32'h0000_0000
`define RCBF_PC_ADDR         32'h0000_0004
`define RCBF_VBP_RESET       32'h0000_0000
`define RCBF_SW_S_BIT        13
`define RCBF_SW_T_BIT        15
`define RCBF_SW_M_BIT        12
`define RCBF_SW_IPL_LSB      8
`define RCBF_IPL_RESET       3'h7
`define RCBF_STATUS_WORD_RST 16'h2700
`define RCBF_DFLT_CLK_MODE   2'h0
`define RCBF_DFLT_BOOT       2'h0
`define RCBF_DFLT_CHIP_MODE  3'h0
`define RCBF_DFLT_DRIVE      1'h1
`define RCBF_DFLT_ADDR_MODE  2'h3
`define RCBF_DFLT_DBG_SEL    1'h0
`define RCBF_CFG_WIDTH       16
`define RCBF_BOOT_LSB        18
`define RCBF_SETTLE_CYCLES   4
`endif

/* File: rcbf_top.sv */
// reset sequencing, boot vector fetch and axi4-lite status registers
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "rcbf_regs.svh"
module rcbf_top
#(
	parameter int SETTLE = `RCBF_SETTLE_CYCLES
)
(
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	// strapping
	input  wire logic         reset_config_enable_n,
	input  wire logic [31:0]  data_pins,
	input  wire logic         debug_port_sel,
	// boot bus
	input  wire logic         bus_grant,
	output logic              rd_req,
	output logic [31:0]       rd_addr,
	output logic              boot_chip_select,
	output logic [1:0]        port_width,
	input  wire logic         rd_ack,
	input  wire logic [31:0]  rd_data,
	input  wire logic         access_err,
	input  wire logic         addr_err,
	// core state
	output logic              core_run,
	output logic              core_halted,
	output logic [31:0]       stack_ptr,
	output logic [31:0]       prog_ctr,
	output logic [15:0]       status_word,
	output logic [31:0]       vector_base_pointer,
	output logic [3:0]        clk_mode_sel,
	output logic              dbg_sel_jtag,
	output logic              local_mem_en,
	// axi4-lite slave
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready
);
	////////////////////////////////////////////////////////////////////////////////
	rcbf_pkg::rcbf_state_t state_q;
	rcbf_pkg::rcbf_state_t state_d;
	logic [7:0]            settle_q;
	logic                  capture;
	logic [1:0]            boot_sel;
	logic [2:0]            chip_mode;
	logic                  drive_full;
	logic [1:0]            addr_mode;
	logic [1:0]            clk_mode;
	logic                  cs_cfg_q;
	logic                  fault_q;
	logic                  mem_en_q;
	logic [31:0]           vbp_q;
	logic [15:0]           sw_q;

	assign capture = (state_q == rcbf_pkg::RCBF_ST_LATCH);

	rcbf_cfg_latch u_cfg
	(
		.ref_clk               (ref_clk),
		.sys_rst               (sys_rst),
		.capture               (capture),
		.reset_config_enable_n (reset_config_enable_n),
		.data_pins             (data_pins),
		.debug_port_sel        (debug_port_sel),
		.boot_sel              (boot_sel),
		.clk_mode              (clk_mode),
		.chip_mode             (chip_mode),
		.drive_full            (drive_full),
		.addr_mode             (addr_mode),
		.dbg_sel_jtag          (dbg_sel_jtag),
		.clk_onehot            (clk_mode_sel)
	);

	////////////////////////////////////////////////////////////////////////////////
	// sequencer
	wire boot_ext    = (boot_sel != rcbf_pkg::RCBF_BOOT_INT32);
	wire any_err     = access_err | addr_err;
	wire in_fetch    = (state_q == rcbf_pkg::RCBF_ST_FETCHSP) | (state_q == rcbf_pkg::RCBF_ST_FETCHPC);
	wire fetch_done  = in_fetch & rd_ack & ~any_err;
	wire settle_end  = (settle_q == 8'(SETTLE - 1));

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			rcbf_pkg::RCBF_ST_RESET:   state_d = rcbf_pkg::RCBF_ST_LATCH;
			rcbf_pkg::RCBF_ST_LATCH:   state_d = rcbf_pkg::RCBF_ST_CSCFG;
			rcbf_pkg::RCBF_ST_CSCFG:
			begin
				if (settle_end && bus_grant)
					state_d = rcbf_pkg::RCBF_ST_FETCHSP;
			end
			rcbf_pkg::RCBF_ST_FETCHSP:
			begin
				if (in_fetch && rd_ack && any_err)
					state_d = rcbf_pkg::RCBF_ST_HALT;
				else if (fetch_done)
					state_d = rcbf_pkg::RCBF_ST_FETCHPC;
			end
			rcbf_pkg::RCBF_ST_FETCHPC:
			begin
				if (in_fetch && rd_ack && any_err)
					state_d = rcbf_pkg::RCBF_ST_HALT;
				else if (fetch_done)
					state_d = rcbf_pkg::RCBF_ST_RUN;
			end
			rcbf_pkg::RCBF_ST_RUN:     state_d = rcbf_pkg::RCBF_ST_RUN;
			rcbf_pkg::RCBF_ST_HALT:    state_d = rcbf_pkg::RCBF_ST_HALT;
			default:                   state_d = rcbf_pkg::RCBF_ST_HALT;
		endcase
	end

	// synchronous reset overrides every state, nothing resumes afterwards
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			state_q <= rcbf_pkg::RCBF_ST_RESET;
		else
			state_q <= state_d;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || state_q != rcbf_pkg::RCBF_ST_CSCFG)
			settle_q <= 8'h00;
		// held at its end value so the fetch starts as soon as grant arrives
		else if (!settle_end)
			settle_q <= settle_q + 8'h01;
	end

	// boot chip select is marked configured once the settle count elapses
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			cs_cfg_q <= 1'b0;
		else if (state_q == rcbf_pkg::RCBF_ST_CSCFG && settle_end)
			cs_cfg_q <= 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			fault_q <= 1'b0;
		// sticky until reset so software can tell a halted boot from a slow one
		else if (in_fetch && rd_ack && any_err)
			fault_q <= 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			stack_ptr <= 32'h0000_0000;
			prog_ctr  <= 32'h0000_0000;
		end
		// vectors land only on a clean acknowledge, a faulted word is never loaded
		else if (fetch_done && state_q == rcbf_pkg::RCBF_ST_FETCHSP)
			stack_ptr <= rd_data;
		else if (fetch_done && state_q == rcbf_pkg::RCBF_ST_FETCHPC)
			prog_ctr  <= rd_data;
	end

	assign rd_req           = in_fetch;
	assign rd_addr          = (state_q == rcbf_pkg::RCBF_ST_FETCHPC) ? `RCBF_PC_ADDR : `RCBF_SP_ADDR;
	assign boot_chip_select = in_fetch & boot_ext & cs_cfg_q;
	assign port_width       = boot_sel;
	assign core_run         = (state_q == rcbf_pkg::RCBF_ST_RUN);
	assign core_halted      = (state_q == rcbf_pkg::RCBF_ST_HALT);

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite write path; core registers software may alter only while running
	logic       aw_got_q;
	logic       w_got_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic       bvalid_q;
	logic [1:0] bresp_q;

	wire do_write   = aw_got_q & w_got_q & ~bvalid_q;
	wire wr_known   = (aw_addr_q == `RCBF_OFF_STATUS_WORD) | (aw_addr_q == `RCBF_OFF_VBP) |
	                  (aw_addr_q == `RCBF_OFF_MEMCTL) | (aw_addr_q == `RCBF_OFF_CTRL);
	wire wr_sw      = do_write & (aw_addr_q == `RCBF_OFF_STATUS_WORD) & core_run;
	wire wr_vbp     = do_write & (aw_addr_q == `RCBF_OFF_VBP) & core_run;
	wire wr_mem     = do_write & (aw_addr_q == `RCBF_OFF_MEMCTL) & core_run & w_strb_q[0];

	assign s_axi_awready = ~aw_got_q & ~bvalid_q;
	assign s_axi_wready  = ~w_got_q & ~bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_q  <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_q  <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wr_known ? 2'h0 : 2'h2;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// byte-lane merge for the word-wide registers
	function automatic logic [31:0] rcbf_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : rcbf_merge

	// status word is 16 bits wide, the two upper byte lanes of a write are dropped
	wire [31:0] sw_merged = rcbf_merge({16'h0000, sw_q}, w_data_q, w_strb_q);

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			sw_q     <= `RCBF_STATUS_WORD_RST;
			vbp_q    <= `RCBF_VBP_RESET;
			mem_en_q <= 1'b0;
		end
		else
		begin
			if (wr_sw)
				sw_q <= sw_merged[15:0];
			if (wr_vbp)
				vbp_q <= rcbf_merge(vbp_q, w_data_q, w_strb_q);
			if (wr_mem)
				mem_en_q <= w_data_q[0];
		end
	end

	assign status_word         = sw_q;
	assign vector_base_pointer = vbp_q;
	assign local_mem_en        = mem_en_q;

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite read path
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	wire [31:0] stat_word = {22'h00_0000, fault_q, cs_cfg_q, core_halted, core_run, 3'h0, state_q};
	wire [31:0] cfg_word  = {16'h0000, 3'h0, dbg_sel_jtag, addr_mode, drive_full, chip_mode, clk_mode, 2'h0, boot_sel};
	// out-of-range or unaligned offsets answer slverr with zero data
	wire        rd_known  = (s_axi_araddr <= `RCBF_OFF_MEMCTL) & (s_axi_araddr[1:0] == 2'h0);
	wire [31:0] rd_mux    = (s_axi_araddr == `RCBF_OFF_CTRL)        ? 32'h0000_0000 :
	                        (s_axi_araddr == `RCBF_OFF_STATUS)      ? stat_word :
	                        (s_axi_araddr == `RCBF_OFF_CONFIG)      ? cfg_word :
	                        (s_axi_araddr == `RCBF_OFF_SP)          ? stack_ptr :
	                        (s_axi_araddr == `RCBF_OFF_PC)          ? prog_ctr :
	                        (s_axi_araddr == `RCBF_OFF_STATUS_WORD) ? {16'h0000, sw_q} :
	                        (s_axi_araddr == `RCBF_OFF_VBP)         ? vbp_q :
	                        (s_axi_araddr == `RCBF_OFF_MEMCTL)      ? {31'h0000_0000, mem_en_q} :
	                                                                  32'h0000_0000;

	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= rd_known ? 2'h0 : 2'h2;
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
	end
endmodule : rcbf_top
`default_nettype wire

/* File: rcbf_top_bench.sv */
// self-checking bench for the reset sequencer and boot fetch
`timescale 1ns/100ps
`default_nettype none
module rcbf_top_bench;
	localparam logic [31:0] SP_W = 32'h2000_FF00;
	localparam logic [31:0] PC_W = 32'hF000_0400;
	logic        ref_clk = 1'b0, sys_rst = 1'b1, reset_config_enable_n = 1'b1;
	logic        debug_port_sel = 1'b0, bus_grant = 1'b0;
	logic [31:0] data_pins = 32'h0000_0000, rd_addr, rd_data, stack_ptr, prog_ctr, vector_base_pointer;
	logic        rd_req, boot_chip_select, rd_ack, access_err, addr_err;
	logic        core_run, core_halted, dbg_sel_jtag, local_mem_en;
	logic [1:0]  port_width, s_axi_bresp, s_axi_rresp, err_sel = 2'h0, r;
	logic [15:0] status_word;
	logic [3:0]  clk_mode_sel, s_axi_wstrb = 4'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lat = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int          err_total = 0, cmp_count = 0;
	rcbf_top #(.SETTLE(2)) dut_u (.ref_clk, .sys_rst, .reset_config_enable_n, .data_pins, .debug_port_sel,
		.bus_grant, .rd_req, .rd_addr, .boot_chip_select, .port_width, .rd_ack, .rd_data, .access_err,
		.addr_err, .core_run, .core_halted, .stack_ptr, .prog_ctr, .status_word, .vector_base_pointer,
		.clk_mode_sel, .dbg_sel_jtag, .local_mem_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	rcbf_boot_mem #(.SP_WORD(SP_W), .PC_WORD(PC_W)) mem_u (.ref_clk, .rd_req, .rd_addr, .rd_ack, .rd_data,
		.access_err, .addr_err, .lat, .err_sel);
	initial
	begin
		forever #25 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////
	function automatic logic [31:0] pins_of(input logic [1:0] c);
		return {12'h000, c, 10'h000, ~c, c[0], c[0], c, c};
	endfunction : pins_of
	function automatic logic [31:0] cfg_of(input logic [1:0] c, input logic g);
		return {19'h0_0000, g, ~c, c[0], c[0], c, c, 2'h0, c};
	endfunction : cfg_of
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	// bus waits are open ended, only the watchdog ends a hung transfer
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic done;
		done = 1'b0;
		rs = 2'h3;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done)
		begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				rs = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic done;
		done = 1'b0;
		rs = 2'h3;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done)
		begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				v = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_rd
	// straps stay put through reset, then flip to prove they are not re-read
	task automatic boot(input logic [1:0] c, input logic en_n, input logic g, input logic [1:0] es,
		input logic [7:0] lt);
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		bus_grant <= 1'b0;
		reset_config_enable_n <= en_n;
		debug_port_sel <= g;
		err_sel <= es;
		lat <= lt;
		data_pins <= pins_of(c);
		repeat (16) @(posedge ref_clk);
		chk("rd_req in reset", 0, rd_req);
		chk("status_word", 32'h0000_2700, status_word);
		chk("vector_base_pointer", 0, vector_base_pointer);
		chk("local_mem_en", 0, local_mem_en);
		sys_rst <= 1'b0;
		repeat (12) @(posedge ref_clk);
		chk("rd_req without grant", 0, rd_req);
		bus_grant <= 1'b1;
		data_pins <= ~pins_of(c);
	endtask : boot
	task automatic wait_done;
		int n;
		n = 0;
		while (!(core_run === 1'b1 || core_halted === 1'b1) && n < 400)
		begin
			@(posedge ref_clk);
			n++;
		end
		chk("boot finished", 1, core_run | core_halted);
	endtask : wait_done
	////////////////////////////////////////
	initial
	begin
		#250000;
		err_total++;
		print_verdict;
	end
	initial
	begin
		for (int c = 0; c < 4; c++)
		begin
			boot(c[1:0], 1'b0, c[0], 2'h0, 8'(c * 2));
			wait_done;
			chk("stack_ptr", SP_W, stack_ptr);
			chk("prog_ctr", PC_W, prog_ctr);
			chk("port_width", c, port_width);
			chk("clk_mode_sel", 32'h1 << c, clk_mode_sel);
			chk("dbg_sel_jtag", c[0], dbg_sel_jtag);
			axi_rd(8'h08, d, r);
			chk("config", cfg_of(c[1:0], c[0]), d);
		end
		boot(2'h3, 1'b1, 1'b0, 2'h0, 8'h00);
		wait_done;
		chk("default port_width", 0, port_width);
		chk("default clk_mode_sel", 1, clk_mode_sel);
		axi_rd(8'h08, d, r);
		chk("default config", 32'h0000_0E00, d);
		// move the core registers so the next reset has something to undo
		axi_wr(8'h14, 32'h0000_0400, r);
		chk("status_word write resp", 0, r);
		chk("status_word written", 32'h0000_0400, status_word);
		axi_wr(8'h18, 32'h1234_5670, r);
		chk("vector_base_pointer written", 32'h1234_5670, vector_base_pointer);
		axi_wr(8'h1C, 32'h0000_0001, r);
		chk("local_mem_en written", 1, local_mem_en);
		for (int e = 1; e < 3; e++)
		begin
			boot(2'h3, 1'b0, 1'b0, 2'(e), 8'h01);
			wait_done;
			repeat (5) @(posedge ref_clk);
			chk("core_halted", 1, core_halted);
			chk("core_run halted", 0, core_run);
		end
		// reset lands in the middle of a slow fetch
		boot(2'h2, 1'b0, 1'b0, 2'h0, 8'd40);
		repeat (20) @(posedge ref_clk);
		chk("rd_req mid fetch", 1, rd_req);
		boot(2'h1, 1'b0, 1'b1, 2'h0, 8'h00);
		wait_done;
		chk("prog_ctr after abort", PC_W, prog_ctr);
		axi_rd(8'h0C, d, r);
		chk("sp register", SP_W, d);
		axi_rd(8'h40, d, r);
		chk("unmapped read resp", 2, r);
		chk("unmapped read data", 0, d);
		axi_wr(8'h40, 32'h0000_0001, r);
		chk("unmapped write resp", 2, r);
		print_verdict;
	end
endmodule : rcbf_top_bench
`default_nettype wire
